// ---- nbtb_host.sv ----
/*
  Host controller for an asynchronous NAND array: runs page read, page program, block erase,
  set/get features and the factory bad-block scan over the strobe pins, guards busy intervals
  and keeps a per-block table of bad marks and program order.
  Assumes the flash pins are wired straight to the device and the io bus is resolved outside.
*/
`timescale 1ns/1ps
module nbtb_host #(
  parameter int READ_TMO_CYC = nbtb_pkg::READ_US * nbtb_pkg::CLK_MHZ,
  parameter int PROG_TMO_CYC = nbtb_pkg::PROG_US * nbtb_pkg::CLK_MHZ,
  parameter int ERASE_TMO_CYC = nbtb_pkg::ERASE_US * nbtb_pkg::CLK_MHZ,
  // last block the scan visits; lowered only to keep simulations short
  parameter logic [12:0] SCAN_LAST = nbtb_pkg::LAST_BLOCK
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // operation request and result
  input wire logic req_valid,
  output logic req_ready,
  input wire nbtb_pkg::nbtb_req_t req,
  output logic done,
  output nbtb_pkg::nbtb_res_t res,
  output logic [13:0] bad_count,
  // write data stream
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read data stream and corrector verdict
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_sector_end,
  input wire logic ecc_err,
  // flash pins
  output nbtb_pkg::nbtb_pins_t flash,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_out
);
  import nbtb_pkg::*;

  typedef struct packed {
    nbtb_state_t state;
    nbtb_req_t req;
    nbtb_res_t res;
    nbtb_ent_t ent;
    nbtb_pins_t pins;
    logic [3:0] tick;
    logic [11:0] idx;
    logic [4:0] gap;
    logic [21:0] wdog;
    logic [7:0] wbyte;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_sector_end;
    logic done;
    logic scan_pg;
    logic scanned;
    logic [13:0] bad_cnt;
    logic rb_s1;
    logic rb_s2;
    logic [7:0] io_s1;
    logic [7:0] io_s2;
  } nbtb_st_t;

  nbtb_st_t st;
  nbtb_st_t next_st;
  logic mem_we;
  logic [12:0] mem_addr;
  nbtb_ent_t mem_wdata;
  nbtb_ent_t mem_rdata;
  logic [7:0] since_we;

  nbtb_mem u_table (
    .mclk(mclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign req_ready = (st.state == S_IDLE);
  assign wr_ready = (st.state == S_WDATA) && (st.tick == 4'h0);
  assign done = st.done;
  assign res = st.res;
  assign bad_count = st.bad_cnt;
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign rd_sector_end = st.rd_sector_end;
  assign flash = st.pins;

  always_comb begin
    logic wr_ph;
    logic rd_ph;
    logic wlast;
    logic rlast;
    logic sample;
    logic stall;
    logic [7:0] wb;
    logic [11:0] len;
    logic [11:0] idx_inc;
    logic [21:0] lim;
    wr_ph = st.state inside {S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_STCMD};
    rd_ph = st.state inside {S_STRD, S_RDATA};
    wlast = (st.tick == WE_PER_CYC - 4'h1);
    rlast = (st.tick == RE_PER_CYC - 4'h1);
    sample = rd_ph && (st.tick == RD_SAMPLE_CYC);
    stall = (st.state == S_WDATA) && (st.tick == 4'h0) && !wr_valid;
    idx_inc = st.idx + 12'h001;
    len = (st.req.op == OP_READ) ? PAGE_BYTES : (st.req.op == OP_SCAN) ? MARK_BYTES : FEAT_BYTES;
    lim = (st.req.op == OP_READ || st.req.op == OP_SCAN || st.req.op == OP_GETF) ?
          22'(READ_TMO_CYC) : (st.req.op == OP_PROG) ? 22'(PROG_TMO_CYC) :
          (st.req.op == OP_ERASE) ? 22'(ERASE_TMO_CYC) : FEAT_TMO_CYC;
    wb = 8'h00;
    if (st.state == S_CMD1) begin
      unique case (st.req.op)
        OP_READ, OP_SCAN: wb = CMD_READ;
        OP_PROG: wb = CMD_PROG;
        OP_ERASE: wb = CMD_ERASE;
        OP_SETF: wb = CMD_SETF;
        OP_GETF: wb = CMD_GETF;
        default: wb = CMD_STATUS;
      endcase
    end else if (st.state == S_ADDR) begin
      unique case (st.idx[2:0])
        3'h0: wb = (st.req.op inside {OP_SETF, OP_GETF}) ? st.req.feat : SPARE_COL[7:0];
        3'h1: wb = (st.req.op == OP_SCAN) ? SPARE_COL[15:8] : 8'h00;
        3'h2: wb = {st.req.block[1:0], st.req.page};
        3'h3: wb = st.req.block[9:2];
        default: wb = {5'h00, st.req.block[12:10]};
      endcase
    end else if (st.state == S_WDATA) begin
      wb = (st.tick == 4'h0) ? wr_data : st.wbyte;
    end else if (st.state == S_CMD2) begin
      wb = (st.req.op == OP_PROG) ? CMD_PROG_GO : (st.req.op == OP_ERASE) ? CMD_ERASE_GO : CMD_READ_GO;
    end else if (st.state == S_STCMD) begin
      wb = CMD_STATUS;
    end

    next_st = st;
    next_st.rb_s1 = ready_busy_out;
    next_st.rb_s2 = st.rb_s1;
    next_st.io_s1 = io_in;
    next_st.io_s2 = st.io_s1;
    next_st.done = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.rd_sector_end = 1'b0;
    // tick restarts at each byte end, so a write byte is 8 cycles and a read byte 12
    next_st.tick = ((wr_ph && !wlast && !stall) || (rd_ph && !rlast)) ? st.tick + 4'h1 : 4'h0;
    mem_we = 1'b0;
    mem_addr = st.req.block;
    mem_wdata = st.ent;

    unique case (st.state)
      S_IDLE: begin
        if (req_valid) begin
          next_st.req = req;
          next_st.res = '0;
          next_st.ent = '0;
          next_st.idx = 12'h000;
          next_st.scan_pg = 1'b0;
          next_st.state = (req.op inside {OP_PROG, OP_ERASE}) ? S_LOOK : S_CMD1;
          if (req.op == OP_SCAN) begin
            next_st.req.block = 13'h0000;
            next_st.req.page = 6'h00;
            next_st.bad_cnt = 14'h0000;
            next_st.scanned = 1'b0;
          end
        end
      end
      S_LOOK: next_st.state = S_CHECK;
      S_CHECK: begin
        next_st.state = S_CMD1;
        if (!st.scanned || mem_rdata.bad) begin
          next_st.res.refused = 1'b1;
          next_st.state = S_DONE;
        end else if (st.req.op == OP_ERASE) begin
          next_st.ent = '0;
        end else if (mem_rdata.used && st.req.page < mem_rdata.last) begin
          next_st.res.refused = 1'b1;
          next_st.state = S_DONE;
        end else if (mem_rdata.used && st.req.page == mem_rdata.last) begin
          // keep used and last, or the count restarts on the next partial program
          next_st.ent = mem_rdata;
          next_st.ent.partial_program_limit = mem_rdata.partial_program_limit + 3'h1;
          if (mem_rdata.partial_program_limit == NOP_MAX) begin
            next_st.res.refused = 1'b1;
            next_st.state = S_DONE;
          end
        end else begin
          next_st.ent = '{bad: 1'b0, used: 1'b1, last: st.req.page, partial_program_limit: 3'h1};
        end
      end
      S_CMD1: begin
        if (wlast) begin
          next_st.state = S_ADDR;
          next_st.idx = (st.req.op == OP_ERASE) ? 12'h002 : 12'h000;
        end
      end
      S_ADDR: begin
        if (wlast) begin
          next_st.idx = idx_inc;
          if (st.req.op inside {OP_SETF, OP_GETF} || st.idx == 12'h004) begin
            next_st.idx = 12'h000;
            next_st.state = (st.req.op inside {OP_PROG, OP_SETF}) ? S_WDATA :
                            (st.req.op == OP_GETF) ? S_GAP : S_CMD2;
          end
        end
      end
      S_WDATA: begin
        if (st.tick == 4'h0 && wr_valid) begin
          next_st.wbyte = wr_data;
        end
        if (wlast) begin
          next_st.idx = idx_inc;
          if (idx_inc == ((st.req.op == OP_PROG) ? PAGE_BYTES : FEAT_BYTES)) begin
            next_st.idx = 12'h000;
            next_st.state = (st.req.op == OP_PROG) ? S_CMD2 : S_GAP;
          end
        end
      end
      S_CMD2: if (wlast) next_st.state = S_GAP;
      S_GAP: begin
        next_st.gap = st.gap + 5'h01;
        if (st.gap == WB_CYC - 5'h01) begin
          next_st.gap = 5'h00;
          next_st.wdog = 22'h000000;
          next_st.state = S_BUSY;
        end
      end
      S_BUSY: begin
        next_st.wdog = st.wdog + 22'h000001;
        if (st.rb_s2) begin
          next_st.state = (st.req.op inside {OP_PROG, OP_ERASE}) ? S_STCMD :
                          (st.req.op == OP_SETF) ? S_DONE : S_RDATA;
        end else if (st.wdog == lim) begin
          next_st.res.timeout = 1'b1;
          next_st.state = S_DONE;
        end
      end
      S_STCMD: if (wlast) next_st.state = S_STGAP;
      S_STGAP: begin
        next_st.gap = st.gap + 5'h01;
        if (st.gap == WHR_CYC - 5'h01) begin
          next_st.gap = 5'h00;
          next_st.state = S_STRD;
        end
      end
      S_STRD: begin
        if (sample && st.io_s2[STATUS_FAIL_BIT]) begin
          next_st.res.fail = 1'b1;
          next_st.ent.bad = 1'b1;
        end
        if (rlast) next_st.state = S_UPD;
      end
      S_RDATA: begin
        if (sample) begin
          next_st.idx = idx_inc;
          if (st.req.op == OP_SCAN) begin
            next_st.ent.bad = (st.io_s2 != MARK_ERASED);
          end else begin
            next_st.rd_data = st.io_s2;
            next_st.rd_valid = 1'b1;
            next_st.rd_sector_end = (st.req.op == OP_READ) && (idx_inc % ECC_SECTOR == 12'h000);
          end
        end
        if (st.req.op == OP_READ) begin
          next_st.res.ecc_err = st.res.ecc_err | ecc_err;
        end
        if (rlast && st.idx == len) begin
          next_st.idx = 12'h000;
          if (st.req.op != OP_SCAN) begin
            next_st.state = S_DONE;
          end else if (st.ent.bad || st.scan_pg) begin
            next_st.state = S_UPD;
          end else begin
            next_st.scan_pg = 1'b1;
            next_st.req.page = 6'h01;
            next_st.state = S_CMD1;
          end
        end
      end
      S_UPD: begin
        mem_we = 1'b1;
        next_st.bad_cnt = st.bad_cnt + {13'h0000, st.ent.bad};
        next_st.state = S_DONE;
        if (st.req.op == OP_SCAN) begin
          if (st.req.block == SCAN_LAST) begin
            next_st.scanned = 1'b1;
          end else begin
            next_st.req.block = st.req.block + 13'h0001;
            next_st.req.page = 6'h00;
            next_st.scan_pg = 1'b0;
            next_st.ent = '0;
            next_st.state = S_CMD1;
          end
        end
      end
      S_DONE: begin
        next_st.done = 1'b1;
        if (st.req.op == OP_READ) next_st.res.ecc_err = st.res.ecc_err | ecc_err;
        next_st.state = S_IDLE;
      end
    endcase

    next_st.pins.ce_n = st.state inside {S_IDLE, S_LOOK, S_CHECK, S_DONE};
    next_st.pins.cle = st.state inside {S_CMD1, S_CMD2, S_STCMD};
    next_st.pins.ale = (st.state == S_ADDR);
    next_st.pins.we_n = !(wr_ph && !stall && st.tick < WE_LOW_CYC);
    next_st.pins.re_n = !(rd_ph && st.tick < RE_LOW_CYC);
    next_st.pins.wp_n = 1'b1;
    next_st.pins.io_oe_n = !wr_ph;
    next_st.pins.io_out = wb;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.pins <= PINS_RST;
    end else begin
      st <= next_st;
    end
  end

  // cycles since the last write strobe rose, saturating
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      since_we <= 8'h00;
    end else if (!st.pins.we_n) begin
      since_we <= 8'h00;
    end else if (since_we != 8'hff) begin
      since_we <= since_we + 8'h01;
    end
  end

  a_wb_busy_window: assert property (@(posedge mclk) disable iff (rst)
    $rose(st.state == S_BUSY) |-> since_we >= 8'(WB_CYC))
    else $error("busy sampled inside the strobe-to-busy window");

  a_nop_page_limit: assert property (@(posedge mclk) disable iff (rst)
    (st.state == S_CHECK && st.req.op == OP_PROG && st.scanned && !mem_rdata.bad &&
     mem_rdata.used && st.req.page == mem_rdata.last && mem_rdata.partial_program_limit == NOP_MAX)
    |=> st.state == S_DONE && st.res.refused)
    else $error("fifth partial program of a page was not refused");

  a_scan_before_write: assert property (@(posedge mclk) disable iff (rst)
    (st.state == S_CHECK && !st.scanned) |=> st.res.refused ##1 st.done)
    else $error("program or erase allowed before the bad block scan");

  a_status_after_op: assert property (@(posedge mclk) disable iff (rst)
    (st.state == S_BUSY && st.rb_s2 && st.req.op inside {OP_PROG, OP_ERASE})
    |=> st.state == S_STCMD ##1 st.pins.cle && !st.pins.we_n)
    else $error("no status read after program or erase");

  a_fail_marks_bad: assert property (@(posedge mclk) disable iff (rst)
    (st.state == S_UPD && st.res.fail) |-> mem_we && mem_wdata.bad)
    else $error("failed block not recorded as bad");

  a_ecc_sector_mark: assert property (@(posedge mclk) disable iff (rst)
    st.rd_sector_end |-> st.rd_valid && st.idx % ECC_SECTOR == 12'h000 && st.idx != 12'h000)
    else $error("sector mark not on a 528-byte boundary");

  a_page_ascending: assert property (@(posedge mclk) disable iff (rst)
    (st.state == S_CHECK && st.req.op == OP_PROG && st.scanned && !mem_rdata.bad &&
     mem_rdata.used && st.req.page < mem_rdata.last) |=> st.state == S_DONE && st.res.refused)
    else $error("out-of-order page program was not refused");
endmodule : nbtb_host

// ---- nbtb_pkg.sv ----
/*
  Shared types and constants for the host-side NAND operation sequencer.
  Assumes a 200 MHz mclk and an x8 asynchronous NAND array of 8192 blocks x 64 pages.
*/
package nbtb_pkg;
  localparam int CLK_MHZ = 200;
  // pin-level byte cycle timing, in ns and in mclk cycles
  localparam int WE_LOW_NS = 20;
  localparam int WE_PER_NS = 40;
  localparam int RE_LOW_NS = 40;
  localparam int RE_PER_NS = 60;
  localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] WE_PER_CYC = 4'((WE_PER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RE_LOW_CYC = 4'((RE_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RE_PER_CYC = 4'((RE_PER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RD_SAMPLE_CYC = 4'(RE_LOW_CYC + 4'h1);
  // strobe_to_busy_window and write-to-read turnaround
  localparam int WB_NS = 100;
  localparam int WHR_NS = 80;
  localparam logic [4:0] WB_CYC = 5'((WB_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] WHR_CYC = 5'((WHR_NS * CLK_MHZ + 999) / 1000);
  // busy watchdog limits, in us; the feature cycle count is derived here, the others in the top module
  localparam int READ_US = 25;
  localparam int FEAT_US = 1;
  localparam int PROG_US = 700;
  localparam int ERASE_US = 10000;
  localparam logic [21:0] FEAT_TMO_CYC = 22'(FEAT_US * CLK_MHZ);
  // array geometry and table limits
  localparam int BLOCKS = 8192;
  localparam logic [12:0] LAST_BLOCK = 13'(BLOCKS - 1);
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam logic [11:0] FEAT_BYTES = 12'h004;
  localparam logic [11:0] MARK_BYTES = 12'h001;
  localparam logic [15:0] SPARE_COL = 16'h0800;
  localparam logic [11:0] ECC_SECTOR = 12'h210;
  localparam logic [2:0] NOP_MAX = 3'h4;
  localparam logic [7:0] MARK_ERASED = 8'hff;
  localparam int STATUS_FAIL_BIT = 0;
  // command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_SETF = 8'hef;
  localparam logic [7:0] CMD_GETF = 8'hee;
  localparam logic [7:0] CMD_STATUS = 8'h70;

  typedef enum logic [2:0] {OP_READ, OP_PROG, OP_ERASE, OP_SETF, OP_GETF, OP_SCAN} nbtb_op_t;
  typedef enum logic [3:0] {
    S_IDLE, S_LOOK, S_CHECK, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_GAP,
    S_BUSY, S_STCMD, S_STGAP, S_STRD, S_RDATA, S_UPD, S_DONE
  } nbtb_state_t;

  typedef struct packed {
    nbtb_op_t op;
    logic [12:0] block;
    logic [5:0] page;
    logic [7:0] feat;
  } nbtb_req_t;

  typedef struct packed {
    logic fail;
    logic refused;
    logic timeout;
    logic ecc_err;
  } nbtb_res_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe_n;
    logic [7:0] io_out;
  } nbtb_pins_t;

  typedef struct packed {
    logic bad;
    logic used;
    logic [5:0] last;
    logic [2:0] partial_program_limit;
  } nbtb_ent_t;

  localparam nbtb_pins_t PINS_RST = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                      re_n: 1'b1, wp_n: 1'b0, io_oe_n: 1'b1, io_out: 8'h00};
endpackage : nbtb_pkg

// ---- nbtb_mem.sv ----
/*
  Block table memory: one entry per block, synchronous write, registered read.
  Assumes the caller holds the address one cycle before it uses the read data.
*/
`timescale 1ns/1ps
module nbtb_mem (
  // clock
  input wire logic mclk,
  // port
  input wire logic we,
  input wire logic [12:0] addr,
  input wire nbtb_pkg::nbtb_ent_t wdata,
  output nbtb_pkg::nbtb_ent_t rdata
);
  import nbtb_pkg::*;

  nbtb_ent_t mem [BLOCKS];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : nbtb_mem

// ---- nbtb_flash_model.sv ----
/*
  Behavioural model of the asynchronous NAND array at the far side of the host sequencer.
  Assumes the bench resolves the io bus; busy times are shortened for simulation.
*/
`timescale 1ns/1ps
module nbtb_flash_model #(
  parameter int READ_NS = 60,
  parameter int PROG_NS = 600,
  parameter int ERASE_NS = 800,
  parameter int FEAT_NS = 500,
  parameter int LOCK_NS = 400,
  parameter int DROP_NS = 50
) (
  // host pins
  input wire nbtb_pkg::nbtb_pins_t flash,
  input wire logic [7:0] io,
  // device drive
  output logic [7:0] dev_io,
  output logic ready_busy_out,
  // scenario control and breaches seen
  input wire logic stretch,
  input wire logic [12:0] lock_blk,
  output logic [7:0] n_viol
);
  import nbtb_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] pbuf [int];
  logic [7:0] feat [int];
  int partial_program_limit [int];
  int lastpg [int];
  bit scanned [BLOCKS];
  logic [7:0] cmd = 8'hff;
  logic [7:0] ab [5];
  logic fail = 1'b0;
  logic need_status = 1'b0;
  int na = 0;
  int col = 0;
  int busy_ns = 0;
  realtime t_wb = -1.0e6;
  event go;
  function automatic int key(input int r, input int c);
    return (r << 12) | c;
  endfunction : key
  function automatic logic [7:0] rd_mem(input int k);
    return mem.exists(k) ? mem[k] : MARK_ERASED;
  endfunction : rd_mem
  initial begin
    dev_io = 8'h00;
    ready_busy_out = 1'b1;
    n_viol = 8'h00;
    mem[key(5 * 64, 2048)] = 8'h00;
    mem[key(9 * 64 + 1, 2048)] = 8'h5a;
  end
  always @(go) begin
    #(DROP_NS);
    ready_busy_out = 1'b0;
    #(stretch ? busy_ns * 40 : busy_ns);
    ready_busy_out = 1'b1;
  end
  task automatic start_busy(input int ns);
    busy_ns = ns;
    t_wb = $realtime;
    -> go;
  endtask : start_busy
  task automatic commit(input bit erase);
    int r;
    int blk;
    int ks[$];
    r = erase ? int'({ab[2], ab[1], ab[0]}) : int'({ab[4], ab[3], ab[2]});
    blk = r >> 6;
    if (!scanned[blk]) n_viol++;
    need_status = 1'b1;
    fail = (blk == lock_blk);
    if (fail) begin
      start_busy(LOCK_NS);
      return;
    end
    if (erase) begin
      foreach (mem[k]) if ((k >> 18) == blk) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      for (int p = 0; p < 64; p++) partial_program_limit.delete(blk * 64 + p);
      lastpg.delete(blk);
      start_busy(ERASE_NS);
    end else begin
      if (lastpg.exists(blk) && (r & 63) < lastpg[blk]) n_viol++;
      partial_program_limit[r] = partial_program_limit.exists(r) ? partial_program_limit[r] + 1 : 1;
      if (partial_program_limit[r] > NOP_MAX) n_viol++;
      lastpg[blk] = r & 63;
      foreach (pbuf[c]) mem[key(r, c)] = rd_mem(key(r, c)) & pbuf[c];
      start_busy(PROG_NS);
    end
  endtask : commit
  always @(posedge flash.we_n) begin
    if (!flash.ce_n && flash.cle) begin
      if ($realtime - t_wb < WB_NS || !ready_busy_out) n_viol++;
      if (need_status && io != CMD_STATUS) n_viol++;
      case (io)
        CMD_READ_GO: begin
          if (col == int'(SPARE_COL)) scanned[{ab[4], ab[3], ab[2]} >> 6] = 1'b1;
          start_busy(READ_NS);
        end
        CMD_PROG_GO: commit(1'b0);
        CMD_ERASE_GO: commit(1'b1);
        default: begin
          if (io == CMD_STATUS) need_status = 1'b0;
          cmd = io;
          na = 0;
          pbuf.delete();
        end
      endcase
    end else if (!flash.ce_n && flash.ale) begin
      if (na < 5) ab[na] = io;
      na++;
      col = (cmd == CMD_SETF || cmd == CMD_GETF) ? 0 : int'({ab[1], ab[0]});
      if (cmd == CMD_GETF) start_busy(FEAT_NS);
    end else if (!flash.ce_n && cmd == CMD_SETF) begin
      feat[ab[0] * 4 + col] = io;
      col++;
      if (col == 4) start_busy(FEAT_NS);
    end else if (!flash.ce_n) begin
      pbuf[col] = io;
      col++;
    end
  end
  always @(negedge flash.re_n) begin
    #15;
    if (cmd == CMD_STATUS) dev_io = {1'b1, ready_busy_out, 5'h00, fail};
    else if (cmd == CMD_GETF) dev_io = feat.exists(ab[0] * 4 + col) ? feat[ab[0] * 4 + col] : 8'h00;
    else dev_io = rd_mem(key({ab[4], ab[3], ab[2]}, col));
  end
  // bus no longer held after the output hold time
  always @(posedge flash.re_n) begin
    col++;
    #15;
    dev_io = ~dev_io;
  end
endmodule : nbtb_flash_model

// ---- tb_nand_busy_timing_bad_block.sv ----
/*
  Self-checking bench for the host NAND sequencer against the behavioural array model.
  Assumes shortened watchdog counts and a 16-block scan; page data transfers dominate run time.
*/
`timescale 1ns/1ps
module tb_nand_busy_timing_bad_block;
  import nbtb_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  nbtb_req_t req = '0;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic ecc_err = 1'b0;
  logic stretch = 1'b0;
  logic req_ready, done, rd_valid, rd_sector_end, wr_ready, ready_busy_out;
  nbtb_res_t res, got;
  logic [13:0] bad_count;
  logic [7:0] rd_data, io_in, dev_io, n_viol;
  nbtb_pins_t flash;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] exp_page [2112];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_sec = 0;
  assign io_in = flash.io_oe_n ? dev_io : flash.io_out;
  always #2.5 mclk = ~mclk;
  nbtb_host #(.READ_TMO_CYC(200), .PROG_TMO_CYC(400), .ERASE_TMO_CYC(400),
    .SCAN_LAST(13'h000f)) nbtb_host_i (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .done(done), .res(res), .bad_count(bad_count), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_sector_end(rd_sector_end),
    .ecc_err(ecc_err), .flash(flash), .io_in(io_in), .ready_busy_out(ready_busy_out));
  nbtb_flash_model nbtb_flash_model_i (.flash(flash), .io(io_in), .dev_io(dev_io),
    .ready_busy_out(ready_busy_out), .stretch(stretch), .lock_blk(13'h0007), .n_viol(n_viol));
  always @(posedge mclk) begin
    if (wr_valid && wr_ready) void'(wq.pop_front());
    if (rd_valid) rq.push_back(rd_data);
    if (rd_sector_end) n_sec++;
    #1;
    wr_valid = wq.size() > 0;
    wr_data = wr_valid ? wq[0] : 8'h00;
  end
  function automatic logic [7:0] after_prog(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;
  endfunction : after_prog
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, g, e);
    end
  endtask : check
  task automatic run_op(input nbtb_op_t op, input int blk, input int pg, input logic [7:0] ft);
    int n;
    n = 0;
    while (ready_busy_out !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    #1;
    check(req_ready, 1, "ready in idle");
    req = '{op: op, block: 13'(blk), page: 6'(pg), feat: ft};
    req_valid = 1'b1;
    @(posedge mclk);
    while (req_ready !== 1'b1 && n < 8000) begin
      @(posedge mclk);
      n++;
    end
    #1;
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000000) begin
      @(posedge mclk);
      n++;
    end
    check(n < 3000000, 1, "operation finished");
    got = res;
    #1;
  endtask : run_op
  task automatic prog_page(input int blk, input int pg, input bit keep);
    logic [7:0] b;
    for (int i = 0; i < 2112; i++) begin
      b = 8'($urandom);
      wq.push_back(b);
      if (!keep) exp_page[i] = after_prog(exp_page[i], b);
    end
    run_op(OP_PROG, blk, pg, 8'h00);
    wq.delete();
  endtask : prog_page
  task automatic read_check(input int blk, input int pg, input string what);
    int nerr;
    nerr = 0;
    rq.delete();
    n_sec = 0;
    run_op(OP_READ, blk, pg, 8'h00);
    check(rq.size(), 2112, what);
    foreach (rq[i]) if (i < 2112 && rq[i] !== exp_page[i]) nerr++;
    check(nerr, 0, what);
    check(n_sec, 4, what);
  endtask : read_check
  // scan cut to 16 blocks; five page writes and three page reads take about 170k cycles
  initial begin
    #1_500_000;
    n_mismatch++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict();
  end
  initial begin
    logic [7:0] fa;
    logic [7:0] fd [4];
    void'($urandom(38597));
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    run_op(OP_PROG, 3, 0, 8'h00);
    check(got.refused, 1, "prog before scan");
    $display("test early program finished");
    for (int t = 0; t < 3; t++) begin
      fa = (t == 0) ? 8'hff : 8'($urandom);
      for (int i = 0; i < 4; i++) begin
        fd[i] = 8'($urandom);
        wq.push_back(fd[i]);
      end
      run_op(OP_SETF, 0, 0, fa);
      check(got, 4'h0, "set features");
      rq.delete();
      run_op(OP_GETF, 0, 0, fa);
      check(rq.size(), 4, "get count");
      for (int i = 0; i < 4; i++) check(rq[i], fd[i], "feature byte");
    end
    $display("test features finished");
    run_op(OP_SCAN, 0, 0, 8'h00);
    check(bad_count, 2, "bad count after scan");
    check(got.timeout, 0, "scan");
    run_op(OP_ERASE, 3, 0, 8'h00);
    check(got, 4'h0, "erase");
    foreach (exp_page[i]) exp_page[i] = MARK_ERASED;
    for (int i = 0; i < 5; i++) begin
      prog_page(3, 5, i == 4);
      check(got.refused, i == 4, "partial program");
    end
    read_check(3, 5, "page data");
    check(got.ecc_err, 0, "clean read");
    prog_page(3, 2, 1'b1);
    check(got.refused, 1, "page below last");
    ecc_err = 1'b1;
    read_check(3, 5, "page data ecc");
    check(got.ecc_err, 1, "corrector verdict");
    ecc_err = 1'b0;
    $display("test program and read finished");
    for (int b = 0; b < 2; b++) begin
      run_op(OP_PROG, b ? 9 : 5, 0, 8'h00);
      check(got.refused, 1, "prog bad block");
      run_op(OP_ERASE, b ? 9 : 5, 0, 8'h00);
      check(got.refused, 1, "erase bad block");
    end
    prog_page(7, 0, 1'b1);
    check(got.fail, 1, "locked block");
    check(bad_count, 3, "failed block recorded");
    run_op(OP_ERASE, 7, 0, 8'h00);
    check(got.refused, 1, "erase failed block");
    run_op(OP_ERASE, 0, 0, 8'h00);
    check(got, 4'h0, "block zero");
    $display("test bad blocks finished");
    stretch = 1'b1;
    run_op(OP_READ, 3, 5, 8'h00);
    check(got.timeout, 1, "slow array");
    stretch = 1'b0;
    read_check(3, 5, "read after timeout");
    check(n_viol, 0, "far side breaches");
    $display("test timeout finished");
    print_verdict();
  end
endmodule : tb_nand_busy_timing_bad_block
